// >>> tb_value_register_mapper.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------------------
// self-checking bench for the value register mapper
// ---------------------------------------------------------------------------
module tb_value_register_mapper;
  import vrm_pkg::*;
  logic        clk, rst_b, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rd_q;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic        obj_rx_valid, obj_tx_valid, reg_rd_valid, reg_wr_valid;
  logic [15:0] obj_rx_value, obj_tx_value, reg_rd_word, reg_wr_word;
  int          errors, checked;
  assign hready = hreadyout;  // single slave
  vrm_mapper DUT (.clk(clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .obj_rx_valid(obj_rx_valid), .obj_rx_value(obj_rx_value),
    .obj_tx_valid(obj_tx_valid), .obj_tx_value(obj_tx_value), .reg_rd_valid(reg_rd_valid),
    .reg_rd_word(reg_rd_word), .reg_wr_valid(reg_wr_valid), .reg_wr_word(reg_wr_word));
  vrm_partner u_far (.clk(clk), .obj_rx_valid(obj_rx_valid), .obj_rx_value(obj_rx_value),
    .reg_rd_valid(reg_rd_valid), .reg_rd_word(reg_rd_word));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task give_verdict;
    if (errors == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // wait for hready at a rising edge, bounded
  task hwait;
    int n;
    n = 0;
    @(posedge clk);
    while (hready !== 1'b1) begin
      n++;
      if (n > 20) begin
        errors++;
        give_verdict;
      end
      @(posedge clk);
    end
  endtask
  // one single word transfer
  task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    hwait;
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    hwait;
    rd_q = hrdata;
  endtask
  task rdc(input logic [7:0] a, input logic [31:0] e);
    ahb(1'b0, a, 32'h0);
    chk(rd_q, e);
  endtask
  task cfg(vrm_pos_t p, vrm_form_t f, logic w, vrm_func_t fn, logic [15:0] fl, ac);
    ahb(1'b1, CTRL_OFS, {24'h0, p, f, w, fn, 1'b1});
    ahb(1'b1, FIELD_OFS, {16'h0, fl});
    ahb(1'b1, ACT_OFS, {16'h0, ac});
  endtask
  // object event, then the write pulse one cycle later
  task obj(input logic [15:0] v, input logic e, input logic [15:0] w);
    u_far.send_obj(v);
    #1;
    chk({31'h0, reg_wr_valid}, {31'h0, e});
    if (e) chk({16'h0, reg_wr_word}, {16'h0, w});
  endtask
  // register read event, then the send pulse one cycle later
  task rdw(input logic [15:0] r, input logic e, input logic [15:0] v);
    u_far.read_reg(r);
    #1;
    chk({31'h0, obj_tx_valid}, {31'h0, e});
    if (e) chk({16'h0, obj_tx_value}, {16'h0, v});
  endtask
  // reset values, read-back, status and unmapped places
  task t_regs;
    rdc(CTRL_OFS, {16'h0, CTRL_RST});
    rdc(FIELD_OFS, {16'h0, FIELD_RST});
    ahb(1'b1, ACT_OFS, 32'hffff07ff);
    rdc(ACT_OFS, 32'h000007ff);
    // a byte-sized write must be ignored
    hsize <= 3'h0;
    ahb(1'b1, ACT_OFS, 32'h0);
    hsize <= 3'h2;
    rdc(ACT_OFS, 32'h000007ff);
    ahb(1'b1, 8'h3c, 32'h1234);
    rdc(8'h3c, 32'h0);
    ahb(1'b1, STATUS_OFS, 32'hffff);
    rdc(STATUS_OFS, 32'h0);
  endtask
  // coil form, 1-byte: above set, equal none, below clear
  task t_coil;
    cfg(PS_LOW, FM_BIT_REG, 1'b0, FN_CFG, FIELD_RST, 16'h0621);
    ahb(1'b1, OBJ_REF_OFS, 32'h40);
    ahb(1'b1, OBJVAL_ST_OFS, 32'h3311);
    ahb(1'b1, OBJVAL_CL_OFS, 32'h0022);
    obj(16'h0150, 1'b1, 16'h0001);
    obj(16'h0040, 1'b0, 16'h0);
    obj(16'h0110, 1'b1, 16'h0000);
    rdw(16'h0001, 1'b1, 16'h0011);
    rdw(16'hfffe, 1'b1, 16'h0022);
    rdc(STATUS_OFS, 32'h0004fffe);
  endtask
  // bit 5 in word, 2-byte compare
  task t_bitword;
    cfg(PS_LOW, FM_BIT_WORD, 1'b1, FN_CFG, 16'h0850, 16'h0206);
    ahb(1'b1, OBJ_REF_OFS, 32'h1234);
    ahb(1'b1, OBJVAL_ST_OFS, 32'hbeef);
    rdw(16'ha5a5, 1'b1, 16'hbeef);
    obj(16'h1300, 1'b1, 16'ha585);
    obj(16'h1234, 1'b1, 16'ha5a5);
    obj(16'h0fff, 1'b0, 16'h0);
    rdw(16'h0000, 1'b0, 16'h0);
  endtask
  // 4-bit field at offset 6
  task t_valword;
    cfg(PS_LOW, FM_VAL_WORD, 1'b0, FN_CFG, 16'h0406, 16'h0121);
    ahb(1'b1, OBJ_REF_OFS, 32'h80);
    ahb(1'b1, REG_REF_OFS, 32'h5);
    ahb(1'b1, REGVAL_HI_OFS, 32'ha);
    ahb(1'b1, REGVAL_LO_OFS, 32'h3);
    ahb(1'b1, OBJVAL_LO_OFS, 32'h77);
    rdw(16'hffff, 1'b0, 16'h0);
    obj(16'h0081, 1'b1, 16'hfebf);
    obj(16'h0010, 1'b1, 16'hfcff);
    rdw(16'h00c0, 1'b1, 16'h0077);
  endtask
  // direct byte transfers over every position
  task automatic t_bytes;
    logic [15:0] rw [6] = '{16'hab12, 16'hab12, 16'hab12, 16'h0085, 16'h8500, 16'h0850};
    logic [15:0] tx [6] = '{16'h0012, 16'h00ab, 16'h0001, 16'hff85, 16'hff85, 16'hff85};
    logic [15:0] wr [6] = '{16'habc3, 16'hc312, 16'hab32, 16'h00c3, 16'hc300, 16'h0c30};
    for (int i = 0; i < 6; i++) begin
      cfg(vrm_pos_t'(i % 3), FM_BIT_REG, 1'b0, vrm_func_t'(1 + i / 3), 16'h0404, 16'h0);
      rdw(rw[i], 1'b1, tx[i]);
      obj(16'h00c3, 1'b1, wr[i]);
    end
  endtask
  // reset in mid-run leaves the channel disabled
  task t_off;
    @(posedge clk);
    rst_b <= 1'b0;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    obj(16'h00ff, 1'b0, 16'h0);
    rdw(16'hffff, 1'b0, 16'h0);
    rdc(CTRL_OFS, 32'h0);
  endtask
  initial begin
    errors = 0;
    checked = 0;
    rst_b = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    t_regs;
    t_coil;
    t_bitword;
    t_valword;
    t_bytes;
    t_off;
    give_verdict;
  end
endmodule

// >>> vrm_cmp.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------------------
// three-way unsigned comparison of a value against its reference
// ---------------------------------------------------------------------------
module vrm_cmp #(
  parameter int WIDTH = 16
) (
  // operands
  input  wire logic [WIDTH-1:0] value,
  input  wire logic [WIDTH-1:0] ref_value,
  // outcome, exactly one is high
  output logic                  above,
  output logic                  equal,
  output logic                  below
);

  // exactly one outcome so that one action at most can follow
  always_comb begin
    above = value > ref_value;
    equal = value == ref_value;
    below = value < ref_value;
  end

endmodule

// >>> vrm_mapper.sv
`timescale 1ns/1ps
// Notes on behaviour
// - bit register: compare, then none/set/clear coil
// - coil set or clear: none or send value
// - bit in word: touch only configured bit
// - bit in word read: none or send value
// - value field: bit count and lsb offset
// - value field write: none or outcome's value
// - value field read: compare, none or send
// - unsigned byte: low, high or field
// - signed byte: low, high or offset field
// - 2-byte channel: same forms and actions
module vrm_mapper
  import vrm_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_b,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // group-object side
  input  wire logic        obj_rx_valid,
  input  wire logic [15:0] obj_rx_value,
  output logic             obj_tx_valid,
  output logic [15:0]      obj_tx_value,
  // modbus register image side
  input  wire logic        reg_rd_valid,
  input  wire logic [15:0] reg_rd_word,
  output logic             reg_wr_valid,
  output logic [15:0]      reg_wr_word
);

  // ---------------------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------------------
  logic [15:0] cfg_q [CFG_WORDS];  // configuration words
  logic        wr_pend_q;          // write data phase pending
  logic [3:0]  wr_idx_q;           // word index of pending write
  logic [15:0] image_q;            // last known register word
  logic [2:0]  outcome_q;          // last outcome: below, equal, above
  logic [15:0] img_d;              // image after a fieldbus event
  logic        wr_go, tx_go;       // an event leads to a write or a send
  logic [15:0] tx_d;               // object value to send
  logic [2:0]  out_d;              // outcome of this cycle
  logic        addr_ok;            // address phase accepted
  logic [3:0]  rd_idx;             // word index of read
  logic [31:0] rd_word;            // read data before the flop
  logic        en;                 // channel enabled
  vrm_func_t   func;               // channel function
  vrm_form_t   form;               // mapping form
  vrm_pos_t    pos;                // byte position
  logic        wide;               // 2-byte channel
  logic [3:0]  fld_ofs, bit_pos;   // field offset, single bit position
  logic [4:0]  fld_cnt;            // field bit count
  logic [15:0] act_w;              // action word
  logic [15:0] obj_v, obj_ref;     // received value and reference, width applied
  logic [15:0] fld_v;              // field pulled from the read word
  logic        oa, oe, ob, ra, re, rb;  // object and register comparison outcomes
  vrm_act_t    act;                // action chosen for object outcome
  logic        rd_bit;             // coil or word bit as read

  // ---------------------------------------------------------------------------
  // field helpers
  // ---------------------------------------------------------------------------
  // mask of cnt ones at off; the 17-bit shift keeps a 16-bit field legal
  function automatic logic [15:0] fmask(input logic [4:0] cnt, input logic [3:0] off);
    logic [16:0] m;
    m = (17'h00001 << cnt) - 17'h00001;
    return m[15:0] << off;
  endfunction
  // put val into the field, leave every other bit alone
  function automatic logic [15:0] finsert(input logic [15:0] w, input logic [15:0] val,
                                          input logic [4:0] cnt, input logic [3:0] off);
    return (w & ~fmask(cnt, off)) | ((val << off) & fmask(cnt, off));
  endfunction
  // pull the field down to bit 0
  function automatic logic [15:0] fextract(input logic [15:0] w, input logic [4:0] cnt,
                                           input logic [3:0] off);
    return (w >> off) & fmask(cnt, 4'h0);
  endfunction

  // ---------------------------------------------------------------------------
  // configuration decode
  // ---------------------------------------------------------------------------
  always_comb begin
    en      = cfg_q[CTRL_OFS[5:2]][CTRL_EN_BIT];
    func    = vrm_func_t'(cfg_q[CTRL_OFS[5:2]][CTRL_FUNC_LSB +: 2]);
    wide    = cfg_q[CTRL_OFS[5:2]][CTRL_WIDE_BIT];
    form    = vrm_form_t'(cfg_q[CTRL_OFS[5:2]][CTRL_FORM_LSB +: 2]);
    pos     = vrm_pos_t'(cfg_q[CTRL_OFS[5:2]][CTRL_POS_LSB +: 2]);
    fld_ofs = cfg_q[FIELD_OFS[5:2]][FLD_OFS_LSB +: 4];
    bit_pos = cfg_q[FIELD_OFS[5:2]][FLD_BIT_LSB +: 4];
    fld_cnt = cfg_q[FIELD_OFS[5:2]][FLD_CNT_LSB +: 5];
    act_w   = cfg_q[ACT_OFS[5:2]];
  end

  // ---------------------------------------------------------------------------
  // comparisons
  // ---------------------------------------------------------------------------
  // a 1-byte channel sees only the low byte of value and reference
  always_comb begin
    obj_v   = wide ? obj_rx_value : {8'h00, obj_rx_value[7:0]};
    obj_ref = wide ? cfg_q[OBJ_REF_OFS[5:2]] : {8'h00, cfg_q[OBJ_REF_OFS[5:2]][7:0]};
    fld_v   = fextract(reg_rd_word, fld_cnt, fld_ofs);
  end
  // object value against object reference
  vrm_cmp #(.WIDTH(16)) u_obj_cmp (
    .value     (obj_v),
    .ref_value (obj_ref),
    .above     (oa),
    .equal     (oe),
    .below     (ob)
  );
  // extracted field against register reference
  vrm_cmp #(.WIDTH(16)) u_reg_cmp (
    .value     (fld_v),
    .ref_value (cfg_q[REG_REF_OFS[5:2]]),
    .above     (ra),
    .equal     (re),
    .below     (rb)
  );

  // ---------------------------------------------------------------------------
  // fieldbus to modbus
  // ---------------------------------------------------------------------------
  // one received value gives one evaluation and at most one write
  always_comb begin
    wr_go = 1'b0;
    img_d = image_q;
    out_d = outcome_q;
    // exactly one outcome is high, so one action is chosen
    act   = vrm_act_t'(oa ? act_w[ACT_HI_LSB +: 2] :
                       oe ? act_w[ACT_EQ_LSB +: 2] : act_w[ACT_LO_LSB +: 2]);
    if (en && obj_rx_valid) begin
      case (func)
        FN_CFG: begin
          out_d = {ob, oe, oa};
          case (form)
            FM_BIT_REG: begin
              // coil image is the whole word, 1 or 0
              if (act == AC_SET || act == AC_CLR) begin
                img_d = {15'h0000, act == AC_SET};
                wr_go = 1'b1;
              end
            end
            FM_BIT_WORD: begin
              if (act == AC_SET || act == AC_CLR) begin
                img_d[bit_pos] = (act == AC_SET);
                wr_go          = 1'b1;
              end
            end
            FM_VAL_WORD: begin
              // any non-zero action writes this outcome's own value
              if (act != AC_NONE) begin
                wr_go = 1'b1;
                if (oa) begin
                  img_d = finsert(image_q, cfg_q[REGVAL_HI_OFS[5:2]], fld_cnt, fld_ofs);
                end else if (oe) begin
                  img_d = finsert(image_q, cfg_q[REGVAL_EQ_OFS[5:2]], fld_cnt, fld_ofs);
                end else begin
                  img_d = finsert(image_q, cfg_q[REGVAL_LO_OFS[5:2]], fld_cnt, fld_ofs);
                end
              end
            end
            default: wr_go = 1'b0;  // unknown form: no reaction
          endcase
        end
        FN_UNS, FN_SGN: begin
          // signed values move as their raw two's complement byte
          wr_go = 1'b1;
          case (pos)
            PS_LOW:   img_d[7:0]  = obj_rx_value[7:0];
            PS_HIGH:  img_d[15:8] = obj_rx_value[7:0];
            PS_FIELD: img_d = finsert(image_q, {8'h00, obj_rx_value[7:0]},
                                      (func == FN_SGN) ? BYTE_BITS : fld_cnt, fld_ofs);
            default:  wr_go = 1'b0;
          endcase
        end
        default: wr_go = 1'b0;
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // modbus to fieldbus
  // ---------------------------------------------------------------------------
  // one read word gives one evaluation and at most one send
  always_comb begin
    tx_go  = 1'b0;
    tx_d   = 16'h0000;
    rd_bit = (form == FM_BIT_REG) ? reg_rd_word[0] : reg_rd_word[bit_pos];
    if (en && reg_rd_valid) begin
      case (func)
        FN_CFG: begin
          if (form == FM_VAL_WORD) begin
            if (ra) begin
              tx_go = act_w[SND_HI_BIT];
              tx_d  = cfg_q[OBJVAL_HI_OFS[5:2]];
            end else if (re) begin
              tx_go = act_w[SND_EQ_BIT];
              tx_d  = cfg_q[OBJVAL_EQ_OFS[5:2]];
            end else begin
              tx_go = act_w[SND_LO_BIT];
              tx_d  = cfg_q[OBJVAL_LO_OFS[5:2]];
            end
          end else if (rd_bit) begin
            tx_go = act_w[SND_ST_BIT];
            tx_d  = cfg_q[OBJVAL_ST_OFS[5:2]];
          end else begin
            tx_go = act_w[SND_CL_BIT];
            tx_d  = cfg_q[OBJVAL_CL_OFS[5:2]];
          end
          if (!wide) begin
            tx_d[15:8] = 8'h00;
          end
        end
        FN_UNS, FN_SGN: begin
          tx_go = 1'b1;
          case (pos)
            PS_LOW:   tx_d = {8'h00, reg_rd_word[7:0]};
            PS_HIGH:  tx_d = {8'h00, reg_rd_word[15:8]};
            PS_FIELD: tx_d = fextract(reg_rd_word,
                                      (func == FN_SGN) ? BYTE_BITS : fld_cnt, fld_ofs);
            default:  tx_go = 1'b0;
          endcase
          // signed values leave sign-extended to 16 bits
          if (func == FN_SGN) begin
            tx_d[15:8] = {8{tx_d[7]}};
          end
        end
        default: tx_go = 1'b0;
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // register image and outcome
  // ---------------------------------------------------------------------------
  // a same-cycle write is built on the old image and wins over the read
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      image_q   <= 16'h0000;
      outcome_q <= 3'h0;
    end else begin
      outcome_q <= out_d;
      if (wr_go) begin
        image_q <= img_d;
      end else if (en && reg_rd_valid) begin
        image_q <= reg_rd_word;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // outputs to both sides
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_wr_valid <= 1'b0;
      reg_wr_word  <= 16'h0000;
      obj_tx_valid <= 1'b0;
      obj_tx_value <= 16'h0000;
    end else begin
      reg_wr_valid <= wr_go;
      obj_tx_valid <= tx_go;
      if (wr_go) begin
        reg_wr_word <= img_d;
      end
      if (tx_go) begin
        obj_tx_value <= tx_d;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // ahb-lite slave
  // ---------------------------------------------------------------------------
  // zero wait states; only whole-word writes are stored
  always_comb begin
    addr_ok   = hsel && htrans[1] && hready;
    rd_idx    = haddr[5:2];
    hreadyout = 1'b1;
    hresp     = 1'b0;
    rd_word   = 32'h0000_0000;
    if (haddr[7:6] == 2'h0) begin
      if (rd_idx < 4'(CFG_WORDS)) begin
        // forward a write whose data phase is now, else read old value
        if (wr_pend_q && wr_idx_q == rd_idx) begin
          rd_word = {16'h0000, hwdata[15:0]};
        end else begin
          rd_word = {16'h0000, cfg_q[rd_idx]};
        end
      end else if (rd_idx == STATUS_OFS[5:2]) begin
        rd_word = {13'h0000, outcome_q, image_q};
      end
    end
  end
  // address phase capture
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_pend_q <= 1'b0;
      wr_idx_q  <= 4'h0;
      hrdata    <= 32'h0000_0000;
    end else begin
      wr_pend_q <= addr_ok && hwrite && hsize == 3'h2 && haddr[7:6] == 2'h0 &&
                   haddr[5:2] < 4'(CFG_WORDS);
      if (addr_ok) begin
        wr_idx_q <= haddr[5:2];
        hrdata   <= hwrite ? 32'h0000_0000 : rd_word;
      end
    end
  end
  // data phase commit; bits above 15 are dropped
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < CFG_WORDS; i++) begin
        cfg_q[i] <= CFG_RST;
      end
      cfg_q[CTRL_OFS[5:2]]  <= CTRL_RST;
      cfg_q[FIELD_OFS[5:2]] <= FIELD_RST;
    end else if (wr_pend_q) begin
      cfg_q[wr_idx_q] <= hwdata[15:0];
    end
  end
endmodule

// >>> vrm_mapper_chk.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------------------
// port checker for the value register mapper
// ---------------------------------------------------------------------------
module vrm_chk (
  // clock and reset
  input wire logic        clk,
  input wire logic        rst_b,
  // bus side
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [31:0] hrdata,
  // event side
  input wire logic        obj_rx_valid,
  input wire logic        obj_tx_valid,
  input wire logic [15:0] obj_tx_value,
  input wire logic        reg_rd_valid,
  input wire logic        reg_wr_valid,
  input wire logic [15:0] reg_wr_word
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // read address phase past the status word
  sequence s_rd_unmapped;
    hsel && htrans[1] && hready && !hwrite && (haddr[7:2] > 6'd13);
  endsequence
  // a pulse that ends after one cycle
  sequence s_wr_ends;
    ##1 !reg_wr_valid;
  endsequence
  sequence s_tx_ends;
    ##1 !obj_tx_valid;
  endsequence
  a_ready_okay: assert property (hreadyout && !hresp)
    else $error("slave not ready or not okay");
  a_unmapped_zero: assert property (s_rd_unmapped |=> hrdata == 32'h0)
    else $error("unmapped read not zero");
  a_wr_has_cause: assert property (reg_wr_valid |-> $past(obj_rx_valid))
    else $error("register write without object event");
  a_tx_has_cause: assert property (obj_tx_valid |-> $past(reg_rd_valid))
    else $error("object send without register read");
  a_wr_one_pulse: assert property (reg_wr_valid && !obj_rx_valid |-> s_wr_ends)
    else $error("register write pulse too long");
  a_tx_one_pulse: assert property (obj_tx_valid && !reg_rd_valid |-> s_tx_ends)
    else $error("object send pulse too long");
  a_wr_word_holds: assert property (!reg_wr_valid |-> $stable(reg_wr_word))
    else $error("register word moved without write");
  a_tx_value_holds: assert property (!obj_tx_valid |-> $stable(obj_tx_value))
    else $error("object value moved without send");
endmodule
bind vrm_mapper vrm_chk u_chk (
  .clk(clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
  .hrdata(hrdata), .obj_rx_valid(obj_rx_valid), .obj_tx_valid(obj_tx_valid),
  .obj_tx_value(obj_tx_value), .reg_rd_valid(reg_rd_valid),
  .reg_wr_valid(reg_wr_valid), .reg_wr_word(reg_wr_word)
);

// >>> vrm_partner.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------------------
// far side: group-object receiver and modbus register reader
// ---------------------------------------------------------------------------
module vrm_partner (
  // clock
  input  wire logic   clk,
  // group-object events
  output logic        obj_rx_valid,
  output logic [15:0] obj_rx_value,
  // modbus read events
  output logic        reg_rd_valid,
  output logic [15:0] reg_rd_word
);
  // idle at time zero
  initial begin
    obj_rx_valid = 1'b0;
    obj_rx_value = 16'h0000;
    reg_rd_valid = 1'b0;
    reg_rd_word  = 16'h0000;
  end
  // one-cycle object event; the line is scrambled afterwards, not held
  task send_obj(input logic [15:0] v);
    @(posedge clk);
    obj_rx_valid <= 1'b1;
    obj_rx_value <= v;
    @(posedge clk);
    obj_rx_valid <= 1'b0;
    obj_rx_value <= ~v;
  endtask
  // one-cycle register read result, same shape
  task read_reg(input logic [15:0] w);
    @(posedge clk);
    reg_rd_valid <= 1'b1;
    reg_rd_word  <= w;
    @(posedge clk);
    reg_rd_valid <= 1'b0;
    reg_rd_word  <= ~w;
  endtask
endmodule

// >>> vrm_pkg.sv
// ---------------------------------------------------------------------------
// value register mapper: shared constants and types
// ---------------------------------------------------------------------------
package vrm_pkg;

  // ---------------------------------------------------------------------------
  // register byte offsets on the ahb-lite slave
  // ---------------------------------------------------------------------------
  localparam logic [7:0] CTRL_OFS      = 8'h00;  // channel function and enable
  localparam logic [7:0] FIELD_OFS     = 8'h04;  // bit count, offset, bit position
  localparam logic [7:0] ACT_OFS       = 8'h08;  // per-outcome actions
  localparam logic [7:0] OBJ_REF_OFS   = 8'h0c;  // object reference value
  localparam logic [7:0] REG_REF_OFS   = 8'h10;  // register reference value
  localparam logic [7:0] REGVAL_HI_OFS = 8'h14;  // field value on above
  localparam logic [7:0] REGVAL_EQ_OFS = 8'h18;  // field value on equal
  localparam logic [7:0] REGVAL_LO_OFS = 8'h1c;  // field value on below
  localparam logic [7:0] OBJVAL_HI_OFS = 8'h20;  // object value on above
  localparam logic [7:0] OBJVAL_EQ_OFS = 8'h24;  // object value on equal
  localparam logic [7:0] OBJVAL_LO_OFS = 8'h28;  // object value on below
  localparam logic [7:0] OBJVAL_ST_OFS = 8'h2c;  // object value on bit set
  localparam logic [7:0] OBJVAL_CL_OFS = 8'h30;  // object value on bit clear
  localparam logic [7:0] STATUS_OFS    = 8'h34;  // read only: image and outcome
  localparam int         CFG_WORDS     = 13;     // writable words before status

  // ---------------------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------------------
  localparam int CTRL_EN_BIT   = 0;   // channel enable
  localparam int CTRL_FUNC_LSB = 1;   // 2 bits, vrm_func_t
  localparam int CTRL_WIDE_BIT = 3;   // 1: 2-byte channel
  localparam int CTRL_FORM_LSB = 4;   // 2 bits, vrm_form_t
  localparam int CTRL_POS_LSB  = 6;   // 2 bits, vrm_pos_t
  localparam int FLD_OFS_LSB   = 0;   // 4 bits, field offset from lsb
  localparam int FLD_BIT_LSB   = 4;   // 4 bits, bit position in word
  localparam int FLD_CNT_LSB   = 8;   // 5 bits, field bit count
  localparam int ACT_HI_LSB    = 0;   // 2 bits, vrm_act_t on above
  localparam int ACT_EQ_LSB    = 2;   // 2 bits, on equal
  localparam int ACT_LO_LSB    = 4;   // 2 bits, on below
  localparam int SND_HI_BIT    = 6;   // send object value on above
  localparam int SND_EQ_BIT    = 7;   // send on equal
  localparam int SND_LO_BIT    = 8;   // send on below
  localparam int SND_ST_BIT    = 9;   // send when bit reads set
  localparam int SND_CL_BIT    = 10;  // send when bit reads clear
  localparam int STAT_OUT_LSB  = 16;  // 3 bits: below, equal, above

  // ---------------------------------------------------------------------------
  // reset values and fixed sizes
  // ---------------------------------------------------------------------------
  localparam logic [15:0] CTRL_RST  = 16'h0000;  // channel disabled
  localparam logic [15:0] FIELD_RST = 16'h0800;  // 8-bit field at offset 0
  localparam logic [15:0] CFG_RST   = 16'h0000;  // every other word
  localparam logic [4:0]  BYTE_BITS = 5'h08;     // width of a 1-byte value

  // ---------------------------------------------------------------------------
  // enumerations
  // ---------------------------------------------------------------------------
  typedef enum logic [1:0] {
    FN_CFG = 2'h0,  // configured value with thresholds
    FN_UNS = 2'h1,  // 1-byte unsigned direct transfer
    FN_SGN = 2'h2   // 1-byte signed direct transfer
  } vrm_func_t;

  typedef enum logic [1:0] {
    FM_BIT_REG  = 2'h0,  // whole bit register (coil)
    FM_BIT_WORD = 2'h1,  // single bit in word register
    FM_VAL_WORD = 2'h2   // value in a field of the word
  } vrm_form_t;

  typedef enum logic [1:0] {
    PS_LOW   = 2'h0,  // low byte
    PS_HIGH  = 2'h1,  // high byte
    PS_FIELD = 2'h2   // configured field
  } vrm_pos_t;

  typedef enum logic [1:0] {
    AC_NONE = 2'h0,  // no reaction
    AC_SET  = 2'h1,  // bit to 1, or write field value
    AC_CLR  = 2'h2   // bit to 0, or write field value
  } vrm_act_t;

endpackage
